// ---- logic/bct_core.sv ----
// Overview of operation
// - Acknowledge alone ends the cycle normally and processing continues.
// - Halt with acknowledge, no fault, ends normally then stops until halt negates.
// - Fault without halt, before or with acknowledge, aborts and takes the trap.
// - Fault with halt, before or with acknowledge, aborts then reruns after halt.
// - Fault arriving two states after a seen acknowledge is ignored; normal end.
// - Termination inputs are judged at even states from state four, N against N+2.
// - During rerun, halt released before fault is illegal; trap through vector zero.
// - During rerun, fault released before halt reruns the aborted cycle.
// - A fault still asserted when the next cycle starts ends it as a fault.
// - Address strobe marks each cycle start; byte strobes mark valid write data.
// - No maximum wait; wait states are added one clock at a time.
// - On writes, direction goes low with address strobe, before data drive.
// - On writes, byte strobes assert only after write data is on the bus.
// - A retry repeats the same function code, address and write data.
// - Read-modify-write cycles are never retried; a fault always traps there.
// - With no acknowledge or fault by state four, stay there and wait.
module bct_core
  import bct_pkg::*;
(
  input  wire logic                ref_clk,
  input  wire logic                sys_rst,
  input  wire logic                req_valid,
  output logic                     req_ready,
  input  wire logic                req_write,
  input  wire logic                req_rmw,
  input  wire logic [FC_W-1:0]     req_fc,
  input  wire logic [ADDR_W-1:0]   req_addr,
  input  wire logic [DATA_W-1:0]   req_wdata,
  input  wire logic [1:0]          req_be,
  output logic                     done_pulse,
  output bct_end_t                 done_kind,
  output logic [DATA_W-1:0]        done_rdata,
  output logic                     trap_pulse,
  output logic [7:0]               trap_vector,
  output logic                     halted,
  input  wire logic                transfer_acknowledge_in_n,
  input  wire logic                bus_fault_in_n,
  input  wire logic                halt_in_n,
  output logic                     address_strobe_out_n,
  output logic                     upper_byte_strobe_n,
  output logic                     lower_byte_strobe_n,
  output logic                     rd_wr_n,
  output logic [FC_W-1:0]          fc_out,
  output logic [ADDR_W-1:0]        addr_out,
  output logic                     addr_oe_n,
  input  wire logic [DATA_W-1:0]   data_in,
  output logic [DATA_W-1:0]        data_out,
  output logic                     data_oe_n
);

  bct_state_t              state_r;
  bct_end_t                kind_r;
  bct_end_t                dec_kind;
  logic                    ack_s;
  logic                    fault_s;
  logic                    halt_s;
  logic                    ack_seen_r;
  logic                    cyc_write_r;
  logic                    cyc_rmw_r;
  logic [FC_W-1:0]         cyc_fc_r;
  logic [ADDR_W-1:0]       cyc_addr_r;
  logic [DATA_W-1:0]       cyc_wdata_r;
  logic [1:0]              cyc_be_r;
  logic                    fault_gone_r;
  logic [2:0]              sync_raw;
  logic [2:0]              sync_out;

  // Far-side inputs are asynchronous, so each gets its own synchroniser.
  assign sync_raw = {transfer_acknowledge_in_n, bus_fault_in_n, halt_in_n};

  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++)
    begin : g_sync
      bct_sync u_sync (
        .ref_clk   (ref_clk),
        .sys_rst   (sys_rst),
        .async_in  (sync_raw[gi]),
        .reset_val (1'b1),
        .sync_out  (sync_out[gi])
      );
    end
  endgenerate

  // Synchronised copies line up with edges of our clock, so the far side need not ensure it.
  assign ack_s   = sync_out[2];
  assign fault_s = sync_out[1];
  assign halt_s  = sync_out[0];

  bct_term_decode u_decode (
    .ack_n_now   (ack_s),
    .fault_n_now (fault_s),
    .halt_n_now  (halt_s),
    .ack_seen    (ack_seen_r),
    .rmw         (cyc_rmw_r),
    .result      (dec_kind)
  );

  // A new request is taken only from idle, and not while halt is held.
  assign req_ready = (state_r == BCT_IDLE) && halt_s;
  assign halted    = (state_r == BCT_HALTED) || (state_r == BCT_RERUN);

  // Capture the cycle so that a retry repeats it exactly.
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      cyc_write_r <= 1'b0;
      cyc_rmw_r   <= 1'b0;
      cyc_fc_r    <= '0;
      cyc_addr_r  <= '0;
      cyc_wdata_r <= '0;
      cyc_be_r    <= 2'b00;
    end
    else if (req_valid && req_ready)
    begin
      cyc_write_r <= req_write;
      cyc_rmw_r   <= req_rmw;
      cyc_fc_r    <= req_fc;
      cyc_addr_r  <= req_addr;
      cyc_wdata_r <= req_wdata;
      cyc_be_r    <= req_be;
    end
  end

  // Main sequencer; one bus state per clock, waits held in S4 without limit.
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      state_r      <= BCT_IDLE;
      kind_r       <= BCT_END_NONE;
      ack_seen_r   <= 1'b0;
      fault_gone_r <= 1'b0;
    end
    else
    begin
      case (state_r)
        BCT_IDLE:
        begin
          if (req_valid && req_ready)
            state_r <= BCT_S0;
        end
        BCT_S0:
          state_r <= BCT_S2;
        BCT_S2:
          state_r <= BCT_S3;
        BCT_S3:
          state_r <= BCT_S4;
        BCT_S4:
        begin
          // Judge inputs at state N; a lingering fault ends a new cycle too.
          ack_seen_r <= 1'b0;
          if (!ack_s || !fault_s)
          begin
            ack_seen_r <= fault_s && !ack_s;
            kind_r     <= dec_kind;
            state_r    <= BCT_S6;
          end
          // Neither input yet: stay in S4 adding one-clock waits.
        end
        BCT_S6:
        begin
          // Second look at N+2; a fault after a seen acknowledge is ignored.
          kind_r  <= dec_kind;
          state_r <= BCT_S7;
        end
        BCT_S7:
        begin
          ack_seen_r <= 1'b0;
          case (kind_r)
            BCT_END_HALT:  state_r <= BCT_HALTED;
            BCT_END_RETRY: state_r <= BCT_RERUN;
            BCT_END_FAULT: state_r <= BCT_FAULT;
            default:       state_r <= BCT_IDLE;
          endcase
          fault_gone_r <= 1'b0;
        end
        BCT_HALTED:
        begin
          if (halt_s)
            state_r <= BCT_IDLE;
        end
        BCT_RERUN:
        begin
          // Fault must rise first; halt rising first is the illegal order.
          if (fault_s)
            fault_gone_r <= 1'b1;
          if (halt_s)
          begin
            if (fault_s && fault_gone_r)
              state_r <= BCT_S0;
            else
            begin
              kind_r  <= BCT_END_ILLEGAL;
              state_r <= BCT_FAULT;
            end
          end
        end
        BCT_FAULT:
        begin
          // The trap is taken only once the fault input has been released.
          if (fault_s)
            state_r <= BCT_IDLE;
        end
        default:
          state_r <= BCT_IDLE;
      endcase
    end
  end

  // Completion and trap reporting; trap vector picks bus fault or illegal order.
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      done_pulse  <= 1'b0;
      done_kind   <= BCT_END_NONE;
      done_rdata  <= '0;
      trap_pulse  <= 1'b0;
      trap_vector <= 8'h00;
    end
    else
    begin
      done_pulse <= 1'b0;
      trap_pulse <= 1'b0;
      if (state_r == BCT_S6 && !cyc_write_r)
        done_rdata <= data_in;
      if (state_r == BCT_S7 && kind_r != BCT_END_RETRY && kind_r != BCT_END_FAULT)
      begin
        done_pulse <= 1'b1;
        done_kind  <= kind_r;
      end
      if (state_r == BCT_FAULT && fault_s)
      begin
        done_pulse  <= 1'b1;
        done_kind   <= kind_r;
        trap_pulse  <= 1'b1;
        trap_vector <= (kind_r == BCT_END_ILLEGAL) ? VEC_ILLEGAL : VEC_BUS_FAULT;
      end
    end
  end

  // Strobes and direction: address strobe from S2, write data at S3, byte strobes at S4 on writes and from S2 on reads.
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      address_strobe_out_n <= 1'b1;
      upper_byte_strobe_n  <= 1'b1;
      lower_byte_strobe_n  <= 1'b1;
      rd_wr_n              <= 1'b1;
      data_oe_n            <= 1'b1;
      data_out             <= '0;
    end
    else
    begin
      case (state_r)
        BCT_S0:
        begin
          address_strobe_out_n <= 1'b0;
          rd_wr_n              <= !cyc_write_r;
          if (!cyc_write_r)
          begin
            upper_byte_strobe_n <= !cyc_be_r[1];
            lower_byte_strobe_n <= !cyc_be_r[0];
          end
        end
        BCT_S2:
        begin
          if (cyc_write_r)
          begin
            data_out  <= cyc_wdata_r;
            data_oe_n <= 1'b0;
          end
        end
        BCT_S3:
        begin
          if (cyc_write_r)
          begin
            upper_byte_strobe_n <= !cyc_be_r[1];
            lower_byte_strobe_n <= !cyc_be_r[0];
          end
        end
        BCT_S6:
        begin
          address_strobe_out_n <= 1'b1;
          upper_byte_strobe_n  <= 1'b1;
          lower_byte_strobe_n  <= 1'b1;
        end
        BCT_S7:
        begin
          rd_wr_n   <= 1'b1;
          data_oe_n <= 1'b1;
        end
        default:
        begin
          address_strobe_out_n <= address_strobe_out_n;
        end
      endcase
    end
  end

  // Address and function code held from S0 until the bus goes idle.
  assign fc_out    = cyc_fc_r;
  assign addr_out  = cyc_addr_r;
  assign addr_oe_n = (state_r == BCT_IDLE) || (state_r == BCT_HALTED) ||
                     (state_r == BCT_RERUN) || (state_r == BCT_FAULT);

  // Strobes rise together at the end of the cycle.
  chk_strobe_release: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (state_r == BCT_S6) |=> address_strobe_out_n && upper_byte_strobe_n && lower_byte_strobe_n)
    else $error("strobes not released after S6");

  chk_write_order: assert property (@(posedge ref_clk) disable iff (sys_rst)
    $fell(upper_byte_strobe_n) && !rd_wr_n |-> !data_oe_n && !address_strobe_out_n)
    else $error("byte strobe before write data");

  chk_dir_before_data: assert property (@(posedge ref_clk) disable iff (sys_rst)
    $fell(data_oe_n) |-> !rd_wr_n && !$past(rd_wr_n))
    else $error("data driven before direction low");

  chk_wait_state: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (state_r == BCT_S4) && ack_s && fault_s |=> state_r == BCT_S4)
    else $error("left S4 without termination");

  chk_normal_end: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (state_r == BCT_S4) && !ack_s && fault_s && halt_s ##1 halt_s |=>
      (state_r == BCT_S7) && kind_r == BCT_END_NORMAL)
    else $error("normal termination missed");

  chk_retry_repeat: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (state_r == BCT_RERUN) && halt_s && fault_s && fault_gone_r |=> state_r == BCT_S0)
    else $error("rerun did not restart cycle");

  chk_illegal_vec: assert property (@(posedge ref_clk) disable iff (sys_rst)
    trap_pulse && done_kind == BCT_END_ILLEGAL |-> trap_vector == VEC_ILLEGAL)
    else $error("illegal order used wrong vector");

  chk_rmw_noretry: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (state_r == BCT_S7) && cyc_rmw_r |-> kind_r != BCT_END_RETRY)
    else $error("read-modify-write retried");

endmodule // bct_core

// ---- logic/bct_pkg.sv ----
package bct_pkg;

  // Width of the external data and address busses.
  localparam int DATA_W = 16;
  localparam int ADDR_W = 24;
  localparam int FC_W   = 3;

  // Number of flops in each input synchroniser.
  localparam int SYNC_STAGES = 2;

  // Bus states are counted in half clocks; one ref_clk cycle is one bus state here.
  // Termination inputs are first looked at in this state.
  localparam logic [4:0] SAMPLE_STATE = 5'h04;
  // Distance in bus states between the two samples that are compared.
  localparam logic [4:0] LATE_STATES  = 5'h02;

  // Exception vector used for an illegal negation order during a rerun.
  localparam logic [7:0] VEC_ILLEGAL   = 8'h00;
  // Exception vector used for the bus error trap.
  localparam logic [7:0] VEC_BUS_FAULT = 8'h02;

  // Bus cycle sequencer states.
  typedef enum logic [3:0] {
    BCT_IDLE   = 4'b0000,
    BCT_S0     = 4'b0001,
    BCT_S2     = 4'b0010,
    BCT_S3     = 4'b0011,
    BCT_S4     = 4'b0100,
    BCT_S6     = 4'b0101,
    BCT_S7     = 4'b0110,
    BCT_HALTED = 4'b0111,
    BCT_RERUN  = 4'b1000,
    BCT_FAULT  = 4'b1001
  } bct_state_t;

  // How a bus cycle was ended.
  typedef enum logic [2:0] {
    BCT_END_NONE    = 3'b000,
    BCT_END_NORMAL  = 3'b001,
    BCT_END_HALT    = 3'b010,
    BCT_END_FAULT   = 3'b011,
    BCT_END_RETRY   = 3'b100,
    BCT_END_ILLEGAL = 3'b101
  } bct_end_t;

endpackage

// ---- logic/bct_sync.sv ----
// Multi-flop synchroniser for one asynchronous level.
module bct_sync
  import bct_pkg::*;
(
  input  wire logic ref_clk,
  input  wire logic sys_rst,
  input  wire logic async_in,
  input  wire logic reset_val,
  output logic      sync_out
);

  logic [SYNC_STAGES-1:0] chain_r;

  // Only the last flop is seen by any logic; earlier ones may be metastable.
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
      chain_r <= {SYNC_STAGES{reset_val}};
    else
      chain_r <= {chain_r[SYNC_STAGES-2:0], async_in};
  end

  assign sync_out = chain_r[SYNC_STAGES-1];

endmodule // bct_sync

// ---- logic/bct_term_decode.sv ----
// Classifies the termination inputs sampled at state N and at N+2.
module bct_term_decode
  import bct_pkg::*;
(
  input  wire logic     ack_n_now,
  input  wire logic     fault_n_now,
  input  wire logic     halt_n_now,
  input  wire logic     ack_seen,
  input  wire logic     rmw,
  output bct_end_t      result
);

  // Inputs are active low; a late fault after a seen acknowledge is ignored.
  always_comb
  begin
    result = BCT_END_NONE;
    if (ack_seen)
      result = halt_n_now ? BCT_END_NORMAL : BCT_END_HALT;
    else if (!fault_n_now && (!halt_n_now) && !rmw)
      result = BCT_END_RETRY;
    else if (!fault_n_now)
      result = BCT_END_FAULT;
    else if (!ack_n_now)
      result = halt_n_now ? BCT_END_NORMAL : BCT_END_HALT;
  end

endmodule // bct_term_decode

// ---- testbench/bct_slave_model.sv ----
// Far side of the bus: a slave and its termination logic, with programmable answers.
module bct_slave_model (
  input  wire logic                       ref_clk,
  input  wire logic                       sys_rst,
  input  wire logic                       address_strobe_out_n,
  input  wire logic                       upper_byte_strobe_n,
  input  wire logic                       lower_byte_strobe_n,
  input  wire logic                       rd_wr_n,
  input  wire logic [bct_pkg::DATA_W-1:0] data_out,
  input  wire logic                       ack_en,
  input  wire logic [4:0]                 ack_dly,
  input  wire logic                       flt_en,
  input  wire logic [4:0]                 flt_dly,
  input  wire logic                       hold_flt,
  input  wire logic [bct_pkg::DATA_W-1:0] rd_val,
  output logic                            transfer_acknowledge_in_n,
  output logic                            bus_fault_in_n,
  output logic [bct_pkg::DATA_W-1:0]      data_in,
  output logic [bct_pkg::DATA_W-1:0]      wr_seen
);
  timeunit 1ns;
  timeprecision 1ns;
  import bct_pkg::*;

  logic [4:0] cnt_r;

  // An unselected data bus shows the inverse word, so a stale sample cannot pass as data.
  assign data_in = (!address_strobe_out_n && rd_wr_n) ? rd_val : ~rd_val;

  // Answers count from the strobe; a held fault survives the strobe to reach the next cycle.
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst || address_strobe_out_n)
    begin
      cnt_r <= 5'h00;
      transfer_acknowledge_in_n <= 1'b1;
      bus_fault_in_n <= sys_rst || !hold_flt || bus_fault_in_n;
    end
    else
    begin
      cnt_r <= cnt_r + 5'h01;
      if (ack_en && cnt_r == ack_dly)
        transfer_acknowledge_in_n <= 1'b0;
      if (flt_en && cnt_r == flt_dly)
        bus_fault_in_n <= 1'b0;
      if (!rd_wr_n && !(upper_byte_strobe_n && lower_byte_strobe_n))
        wr_seen <= data_out;
    end
  end
endmodule // bct_slave_model

// ---- testbench/test_bus_cycle_termination.sv ----
module test_bus_cycle_termination;
  timeunit 1ns;
  timeprecision 1ns;
  import bct_pkg::*;

  logic              ref_clk, sys_rst, req_valid, req_ready, req_write, req_rmw, as_q;
  logic              done_pulse, trap_pulse, halted, halt_in_n, rd_wr_n, addr_oe_n, data_oe_n;
  logic              transfer_acknowledge_in_n, bus_fault_in_n, address_strobe_out_n;
  logic              upper_byte_strobe_n, lower_byte_strobe_n, ack_en, flt_en, hold_flt;
  logic [FC_W-1:0]   req_fc, fc_out, as_fc;
  logic [ADDR_W-1:0] req_addr, addr_out, as_addr;
  logic [DATA_W-1:0] req_wdata, done_rdata, data_in, data_out, rd_val, wr_seen, last_rd;
  logic [1:0]        req_be;
  logic [7:0]        trap_vector, last_vec;
  logic [4:0]        ack_dly, flt_dly;
  bct_end_t          done_kind, last_kind;
  int                n_errors, total_checks, n_as, n_done, n_trap, as0, tr0;
  time               t0, t_done;

  bct_core dut (.*);
  bct_slave_model far_end (.*);

  // Free-running clock at 100 MHz.
  initial ref_clk = 1'b0;
  always #5 ref_clk = ~ref_clk;

  task automatic tally_and_finish;
  begin
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  end
  endtask

  task automatic cmp(input logic [23:0] got, input logic [23:0] exp, input string what);
  begin
    total_checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
    end
  end
  endtask

  // Watches the bus between edges: counts starts and ends, and checks strobe ordering.
  always @(negedge ref_clk)
  begin
    if (!sys_rst)
    begin
      if (!address_strobe_out_n && as_q)
      begin
        n_as++;
        as_addr = addr_out;
        as_fc = fc_out;
        cmp(24'(addr_oe_n), 24'h00_0000, "address not driven");
      end
      if (trap_pulse === 1'b1)
      begin
        n_trap++;
        last_vec = trap_vector;
      end
      if (done_pulse === 1'b1)
      begin
        n_done++;
        last_kind = done_kind;
        last_rd = done_rdata;
        t_done = $time;
      end
      if (!(upper_byte_strobe_n && lower_byte_strobe_n))
        cmp(24'(address_strobe_out_n), 24'h00_0000, "byte strobe alone");
      if (!rd_wr_n && !(upper_byte_strobe_n && lower_byte_strobe_n))
        cmp(24'(data_oe_n), 24'h00_0000, "strobe before data");
      if (!data_oe_n)
        cmp(24'(rd_wr_n), 24'h00_0000, "data before direction");
    end
    as_q = address_strobe_out_n;
  end

  // Waits for: 0 a done, 1 halted high, 2 halted low, 3 a trap, 4 a cycle start.
  task automatic wait_for(input int sel);
    int d0;
  begin
    d0 = n_done;
    for (int i = 0; i < 200; i++)
    begin
      @(negedge ref_clk);
      if ((sel == 0 && n_done != d0) || (sel == 1 && halted === 1'b1) ||
          (sel == 2 && halted === 1'b0) || (sel == 3 && n_trap != tr0) ||
          (sel == 4 && n_as != as0))
        return;
    end
    n_errors++;
    $display("BAD %0t wait %0d ran out", $time, sel);
    tally_and_finish();
  end
  endtask

  // Sets the far side's answer at a clock edge.
  task automatic far(input logic ae, input logic [4:0] ad, input logic fe,
                     input logic [4:0] fd, input logic hf);
  begin
    @(posedge ref_clk);
    ack_en <= ae;
    ack_dly <= ad;
    flt_en <= fe;
    flt_dly <= fd;
    hold_flt <= hf;
  end
  endtask

  // Offers one request and returns at the edge that takes it.
  task automatic start(input logic w, input logic rmw, input logic [23:0] a);
    int i;
  begin
    @(posedge ref_clk);
    req_valid <= 1'b1;
    req_write <= w;
    req_rmw <= rmw;
    req_fc <= a[2:0];
    req_addr <= a;
    req_wdata <= a[15:0] ^ 16'hA5A5;
    for (i = 0; i < 50; i++)
    begin
      @(negedge ref_clk);
      if (req_ready === 1'b1)
        break;
    end
    if (i == 50)
    begin
      n_errors++;
      $display("BAD %0t request not taken", $time);
      tally_and_finish();
    end
    @(posedge ref_clk);
    req_valid <= 1'b0;
    t0 = $time;
    as0 = n_as;
    tr0 = n_trap;
  end
  endtask

  task automatic sc_read;
  begin
    far(1'b1, 5'h01, 1'b0, 5'h00, 1'b0);
    start(1'b0, 1'b0, 24'h12_3456);
    wait_for(0);
    cmp(24'(last_kind), 24'(BCT_END_NORMAL), "read end");
    cmp(24'(last_rd), 24'(rd_val), "read data");
    cmp(24'(n_as - as0), 24'h00_0001, "one start");
    cmp(as_addr, 24'h12_3456, "address");
    // Only the upper byte is asked for, so the lower strobe must stay idle.
    @(posedge ref_clk);
    req_be <= 2'b10;
    start(1'b0, 1'b0, 24'h12_3458);
    wait_for(4);
    cmp(24'({upper_byte_strobe_n, lower_byte_strobe_n}), 24'h00_0001, "upper only");
    wait_for(0);
    @(posedge ref_clk);
    req_be <= 2'b11;
  end
  endtask

  // A slow slave: wait states must stretch the cycle until the late acknowledge.
  task automatic sc_write_wait;
  begin
    far(1'b1, 5'h0C, 1'b0, 5'h00, 1'b0);
    start(1'b1, 1'b0, 24'h00_8422);
    wait_for(0);
    cmp(24'(last_kind), 24'(BCT_END_NORMAL), "write end");
    cmp(24'(wr_seen), 24'(16'h8422 ^ 16'hA5A5), "write data");
    cmp(24'((t_done - t0) / 10 > 14), 24'h00_0001, "waited");
  end
  endtask

  // Fault alone, then fault together with the acknowledge.
  task automatic sc_fault;
  begin
    for (int k = 0; k < 2; k++)
    begin
      far(k[0], 5'h02, 1'b1, 5'h02, 1'b0);
      start(1'b0, 1'b0, 24'h40_0000);
      wait_for(0);
      cmp(24'(last_kind), 24'(BCT_END_FAULT), "fault end");
      cmp(24'(n_trap - tr0), 24'h00_0001, "fault trap");
      cmp(24'(last_vec), 24'(VEC_BUS_FAULT), "fault vector");
    end
  end
  endtask

  // A late fault is ignored, but still held it ends the following cycle.
  task automatic sc_late;
  begin
    far(1'b1, 5'h01, 1'b1, 5'h03, 1'b1);
    start(1'b0, 1'b0, 24'h00_0100);
    wait_for(0);
    cmp(24'(last_kind), 24'(BCT_END_NORMAL), "late fault");
    cmp(24'(n_trap - tr0), 24'h00_0000, "late no trap");
    far(1'b0, 5'h01, 1'b0, 5'h00, 1'b1);
    start(1'b0, 1'b0, 24'h00_0102);
    wait_for(4);
    far(1'b0, 5'h01, 1'b0, 5'h00, 1'b0);
    wait_for(0);
    cmp(24'(last_kind), 24'(BCT_END_FAULT), "held fault");
    cmp(24'(n_trap - tr0), 24'h00_0001, "held trap");
  end
  endtask

  task automatic sc_halt;
  begin
    far(1'b1, 5'h03, 1'b0, 5'h00, 1'b0);
    start(1'b0, 1'b0, 24'h00_2000);
    halt_in_n <= 1'b0;
    wait_for(0);
    cmp(24'(last_kind), 24'(BCT_END_HALT), "halt end");
    wait_for(1);
    cmp(24'(req_ready), 24'h00_0000, "refused while halted");
    @(posedge ref_clk);
    halt_in_n <= 1'b1;
    wait_for(2);
    cmp(24'(n_as - as0), 24'h00_0001, "no cycle while halted");
  end
  endtask

  // Fault with halt on a write; fault drops first, then halt, and the write runs again.
  task automatic sc_retry;
  begin
    far(1'b0, 5'h00, 1'b1, 5'h02, 1'b0);
    start(1'b1, 1'b0, 24'h03_0F0E);
    halt_in_n <= 1'b0;
    wait_for(1);
    cmp(24'(n_trap - tr0), 24'h00_0000, "retry no trap");
    repeat (3) @(posedge ref_clk);
    far(1'b1, 5'h04, 1'b0, 5'h00, 1'b0);
    halt_in_n <= 1'b1;
    wait_for(2);
    wait_for(0);
    cmp(24'(last_kind), 24'(BCT_END_NORMAL), "rerun end");
    cmp(24'(n_as - as0), 24'h00_0002, "rerun start");
    cmp(as_addr, 24'h03_0F0E, "rerun address");
    cmp(24'(as_fc), 24'h00_0006, "rerun code");
    cmp(24'(wr_seen), 24'(16'h0F0E ^ 16'hA5A5), "rerun data");
  end
  endtask

  // Halt released while the fault is still held.
  task automatic sc_illegal;
  begin
    far(1'b0, 5'h00, 1'b1, 5'h02, 1'b1);
    start(1'b0, 1'b0, 24'h00_0ABC);
    halt_in_n <= 1'b0;
    wait_for(1);
    @(posedge ref_clk);
    halt_in_n <= 1'b1;
    repeat (2) @(posedge ref_clk);
    far(1'b0, 5'h00, 1'b0, 5'h00, 1'b0);
    wait_for(3);
    cmp(24'(last_vec), 24'(VEC_ILLEGAL), "illegal vector");
  end
  endtask

  task automatic sc_rmw;
  begin
    far(1'b0, 5'h00, 1'b1, 5'h02, 1'b0);
    start(1'b0, 1'b1, 24'h00_0C00);
    halt_in_n <= 1'b0;
    wait_for(3);
    cmp(24'(last_vec), 24'(VEC_BUS_FAULT), "locked trap");
    @(posedge ref_clk);
    halt_in_n <= 1'b1;
    wait_for(2);
    repeat (8) @(posedge ref_clk);
    cmp(24'(n_as - as0), 24'h00_0001, "locked no rerun");
  end
  endtask

  // No answer at all: the cycle must wait without limit, and only a reset ends it.
  task automatic sc_stall;
    int dn;
  begin
    far(1'b0, 5'h00, 1'b0, 5'h00, 1'b0);
    dn = n_done;
    start(1'b0, 1'b0, 24'h00_0E00);
    repeat (100) @(negedge ref_clk);
    cmp(24'(n_done - dn), 24'h00_0000, "stall ended");
    cmp(24'(address_strobe_out_n), 24'h00_0000, "stall strobe");
    @(posedge ref_clk);
    sys_rst <= 1'b1;
    repeat (3) @(posedge ref_clk);
    sys_rst <= 1'b0;
    @(negedge ref_clk);
    cmp(24'(address_strobe_out_n), 24'h00_0001, "reset strobe");
    repeat (2) @(posedge ref_clk);
  end
  endtask

  // Main sequence: reset, then every scenario in turn.
  initial
  begin
    sys_rst = 1'b1;
    req_valid = 1'b0;
    req_write = 1'b0;
    req_rmw = 1'b0;
    req_fc = 3'h0;
    req_addr = 24'h00_0000;
    req_wdata = 16'h0000;
    req_be = 2'b11;
    halt_in_n = 1'b1;
    ack_en = 1'b0;
    ack_dly = 5'h01;
    flt_en = 1'b0;
    flt_dly = 5'h00;
    hold_flt = 1'b0;
    rd_val = 16'hC35A;
    as_q = 1'b1;
    repeat (20) @(posedge ref_clk);
    sys_rst <= 1'b0;
    repeat (2) @(posedge ref_clk);
    sc_read();
    sc_write_wait();
    sc_fault();
    sc_late();
    sc_halt();
    sc_retry();
    sc_illegal();
    sc_rmw();
    sc_stall();
    tally_and_finish();
  end
endmodule // test_bus_cycle_termination
